/* hw/acm_pkg.sv */
/*
 * shared constants and carrier types of the converter channel
 * configuration block: register indices, field layout, reset values.
 * assumes a single 200 MHz pclk domain.
 */
package acm_pkg;
    localparam int unsigned ACM_LANES = 4;
    localparam int unsigned ACM_RES_W = 24;
    // register indices; byte address is four times the index
    localparam logic [2:0] IDX_SLEEP = 3'h0;
    localparam logic [2:0] IDX_PROF_A = 3'h1;
    localparam logic [2:0] IDX_PROF_B = 3'h2;
    localparam logic [2:0] IDX_ASSIGN = 3'h3;
    localparam logic [2:0] IDX_STATUS = 3'h4;
    localparam logic [2:0] IDX_LAST = 3'h4;
    localparam int unsigned ADDR_W = 12;
    // reset values
    localparam logic [7:0] RST_SLEEP = 8'h00;
    localparam logic [7:0] RST_PROF = 8'h0D;
    localparam logic [7:0] RST_ASSIGN = 8'h00;
    // implemented bits
    localparam logic [7:0] MASK_SLEEP = 8'h0F;
    localparam logic [7:0] MASK_PROF = 8'h0F;
    localparam logic [7:0] MASK_ASSIGN = 8'h33;
    // field positions
    localparam int unsigned PROF_FILT_BIT = 3;
    localparam int unsigned PROF_DEC_LSB = 0;
    localparam int unsigned ASSIGN_LO_LSB = 0;
    localparam int unsigned ASSIGN_HI_LSB = 4;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_OVR_BIT = 1;
    // decimation: ratio is 2**exp, exp = base + code, capped
    localparam logic [3:0] DEC_BASE_EXP = 4'h5;
    localparam logic [3:0] DEC_MAX_EXP = 4'hA;
    localparam logic [2:0] DEC_CAP_CODE = 3'h5;
    localparam int unsigned TICK_W = 10;
    // output buffer
    localparam int unsigned FIFO_DEPTH = 8;

    typedef struct packed {
        logic sinc5;
        logic [2:0] dec_code;
    } acm_prof_t;

    typedef struct packed {
        logic err;
        logic rep_data;
        logic sinc5;
        logic [2:0] spare;
        logic [1:0] lane;
    } acm_hdr_t;

    typedef struct packed {
        acm_hdr_t hdr;
        logic [ACM_RES_W-1:0] data;
    } acm_word_t;

    typedef enum logic {
        ST_IDLE = 1'b0,
        ST_SEND = 1'b1
    } acm_state_t;
endpackage : acm_pkg

/* hw/acm_top.sv */
/*
 * converter channel configuration block: APB register bank for lane
 * standby, two filter/decimation profiles and the lane-to-profile map,
 * plus the frame builder that emits one header+result word per lane
 * into an 8-word FIFO at the fastest selected output rate.
 * assumes mod_tick and lane_result come from logic on pclk, and that
 * the filter datapath consumes the lane_* configuration outputs.
 */
// Design decision made here: the APB interface to the registers.
// What this block does
// - standby bits 3:0, reset zero, one per lane
// - sleeping lane sends zero header and data
// - lane 0 standby turns off common-mode output
// - lane 2 standby turns off crystal drive
// - profile A: filter bit 3, decimation bits 2:0
// - profile B: same layout as profile A
// - codes 0-4 give 32..512, 5-7 give 1024
// - assignment bits 5,4,1,0 pick profile per lane
// - data ready at fastest selected rate
// - slower lanes send zero data, repeat flag
`timescale 1ns/1ps

module acm_fifo #(
    parameter int unsigned WIDTH = 32,
    parameter int unsigned DEPTH = 8
) (
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic in_valid, // write request
    output logic in_ready, // room for a word
    input wire logic [WIDTH-1:0] in_data, // word written
    output logic out_valid, // word available
    input wire logic out_ready, // reader takes the word
    output logic [WIDTH-1:0] out_data // oldest word
);
    localparam int unsigned PW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW-1:0] wr_ptr;
    logic [PW-1:0] rd_ptr;
    logic [PW:0] count;
    logic push;
    logic pop;

    assign in_ready = (count != (PW+1)'(DEPTH));
    assign out_valid = (count != '0);
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;
    assign out_data = mem[rd_ptr];

    always_ff @(posedge pclk)
    begin
        if (push)
        begin
            mem[wr_ptr] <= in_data;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == PW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == PW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : acm_fifo

module acm_top
    import acm_pkg::*;
(
    input wire logic pclk, // 200 MHz clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb access phase
    input wire logic pwrite, // apb direction
    input wire logic [ADDR_W-1:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error on unmapped address
    input wire logic mod_tick, // one pulse per modulator sample
    input wire logic [ACM_LANES-1:0][ACM_RES_W-1:0] lane_result, // filter outputs
    output logic drdy, // data ready pulse, one per frame
    output logic frame_valid, // stream word available
    input wire logic frame_ready, // stream consumer takes word
    output acm_word_t frame_word, // header and result
    output logic [ACM_LANES-1:0] lane_sleep, // lane standby
    output logic [ACM_LANES-1:0] lane_sinc5, // lane filter choice
    output logic [ACM_LANES-1:0][2:0] lane_dec_code, // lane decimation code
    output logic common_mode_voltage_output, // common-mode output enable
    output logic xtal_drive_en // crystal excitation enable
);
    logic [7:0] channel_sleep_bits;
    acm_prof_t profile_a_settings;
    acm_prof_t profile_b_settings;
    logic [7:0] profile_assignment;
    logic overrun;
    acm_state_t state;
    logic [1:0] send_idx;
    logic [TICK_W-1:0] tick_cnt;
    logic [TICK_W-1:0] next_tick;
    acm_word_t frame_buf [ACM_LANES];
    acm_word_t next_word [ACM_LANES];
    logic [ACM_LANES-1:0] lane_pick;
    logic [ACM_LANES-1:0] lane_hit;
    logic frame_hit;
    logic fifo_in_ready;
    logic push_word;
    logic last_word;
    logic [2:0] reg_idx;
    logic mapped;
    logic wr_en;
    logic [7:0] wbyte;

    function automatic logic [3:0] dec_exp(input logic [2:0] code);
        if (code >= DEC_CAP_CODE)
        begin
            return DEC_MAX_EXP;
        end
        return DEC_BASE_EXP + {1'b0, code};
    endfunction : dec_exp

    // true when the low exp bits of the tick count are all zero
    function automatic logic on_boundary(input logic [TICK_W-1:0] t, input logic [3:0] e);
        logic [TICK_W-1:0] m;
        m = TICK_W'((11'h001 << e) - 11'h001);
        return (t & m) == '0;
    endfunction : on_boundary

    // ---------------- apb slave ----------------
    assign reg_idx = paddr[4:2];
    assign mapped = (paddr[ADDR_W-1:5] == '0) && (paddr[1:0] == 2'h0)
                    && (reg_idx <= IDX_LAST);
    assign pready = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign wr_en = psel && penable && pwrite && mapped;
    assign wbyte = pwdata[7:0];

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            channel_sleep_bits <= RST_SLEEP;
        end
        else if (wr_en && reg_idx == IDX_SLEEP)
        begin
            channel_sleep_bits <= wbyte & MASK_SLEEP;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            profile_a_settings <= acm_prof_t'(RST_PROF[3:0]);
        end
        else if (wr_en && reg_idx == IDX_PROF_A)
        begin
            profile_a_settings <= acm_prof_t'(wbyte[3:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            profile_b_settings <= acm_prof_t'(RST_PROF[3:0]);
        end
        else if (wr_en && reg_idx == IDX_PROF_B)
        begin
            profile_b_settings <= acm_prof_t'(wbyte[3:0]);
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            profile_assignment <= RST_ASSIGN;
        end
        else if (wr_en && reg_idx == IDX_ASSIGN)
        begin
            // bits 7:6 and 3:2 stay zero
            profile_assignment <= wbyte & MASK_ASSIGN;
        end
    end

    // overrun: a frame was due while the last was still being sent
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            overrun <= 1'b0;
        end
        else if (frame_hit && state == ST_SEND)
        begin
            // a new event beats a same-cycle clear
            overrun <= 1'b1;
        end
        else if (wr_en && reg_idx == IDX_STATUS && wbyte[STAT_OVR_BIT])
        begin
            overrun <= 1'b0;
        end
    end

    // read data captured in the setup phase, stable through access
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
        end
        else if (psel && !penable && !pwrite)
        begin
            prdata <= 32'h0000_0000;
            if (mapped)
            begin
                case (reg_idx)
                    IDX_SLEEP: prdata[7:0] <= channel_sleep_bits;
                    IDX_PROF_A: prdata[3:0] <= profile_a_settings;
                    IDX_PROF_B: prdata[3:0] <= profile_b_settings;
                    IDX_ASSIGN: prdata[7:0] <= profile_assignment;
                    IDX_STATUS:
                    begin
                        prdata[STAT_BUSY_BIT] <= (state == ST_SEND);
                        prdata[STAT_OVR_BIT] <= overrun;
                    end
                    default: prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ---------------- lane configuration ----------------
    assign lane_pick = {profile_assignment[ASSIGN_HI_LSB+1],
                        profile_assignment[ASSIGN_HI_LSB],
                        profile_assignment[ASSIGN_LO_LSB+1],
                        profile_assignment[ASSIGN_LO_LSB]};
    assign lane_sleep = channel_sleep_bits[ACM_LANES-1:0];
    assign common_mode_voltage_output = !channel_sleep_bits[0];
    assign xtal_drive_en = !channel_sleep_bits[2];

    assign next_tick = tick_cnt + 1'b1;

    generate
        for (genvar i = 0; i < ACM_LANES; i++)
        begin : g_lane
            acm_prof_t prof;
            // 0 picks A, 1 picks B
            assign prof = lane_pick[i] ? profile_b_settings : profile_a_settings;
            assign lane_sinc5[i] = prof.sinc5;
            assign lane_dec_code[i] = prof.dec_code;
            // lane result due every 2**exp ticks
            assign lane_hit[i] = mod_tick && on_boundary(next_tick, dec_exp(prof.dec_code));

            always_comb
            begin
                next_word[i] = '0;
                if (!lane_sleep[i])
                begin
                    next_word[i].hdr.lane = 2'(i);
                    next_word[i].hdr.sinc5 = prof.sinc5;
                    if (lane_hit[i])
                    begin
                        next_word[i].data = lane_result[i];
                    end
                    else
                    begin
                        next_word[i].hdr.rep_data = 1'b1;
                    end
                end
                // sleeping lane keeps its slot, all zero
            end
        end
    endgenerate

    // ratios are powers of two, so the fastest awake lane's boundary
    // is the OR of all awake lanes' boundaries
    // frame at fastest awake rate; with every lane asleep, at fastest rate of all lanes
    assign frame_hit = (&lane_sleep) ? |lane_hit : |(lane_hit & ~lane_sleep);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt <= '0;
        end
        else if (mod_tick)
        begin
            tick_cnt <= next_tick;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            drdy <= 1'b0;
        end
        else
        begin
            drdy <= frame_hit && state == ST_IDLE;
        end
    end

    // ---------------- frame sender ----------------
    assign push_word = (state == ST_SEND) && fifo_in_ready;
    assign last_word = send_idx == 2'(ACM_LANES - 1);

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ST_IDLE;
            send_idx <= '0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                begin
                    if (frame_hit)
                    begin
                        state <= ST_SEND;
                        send_idx <= '0;
                    end
                end
                ST_SEND:
                begin
                    // a full FIFO stalls the sender here
                    if (push_word)
                    begin
                        send_idx <= send_idx + 1'b1;
                        if (last_word)
                        begin
                            state <= ST_IDLE;
                        end
                    end
                end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // snapshot keeps one frame coherent while the FIFO drains
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int k = 0; k < ACM_LANES; k++)
            begin
                frame_buf[k] <= '0;
            end
        end
        else if (frame_hit && state == ST_IDLE)
        begin
            for (int k = 0; k < ACM_LANES; k++)
            begin
                frame_buf[k] <= next_word[k];
            end
        end
    end

    acm_fifo #(
        .WIDTH($bits(acm_word_t)),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .pclk(pclk),
        .presetn(presetn),
        .in_valid(state == ST_SEND),
        .in_ready(fifo_in_ready),
        .in_data(frame_buf[send_idx]),
        .out_valid(frame_valid),
        .out_ready(frame_ready),
        .out_data(frame_word)
    );
endmodule : acm_top

/* dv/acm_consumer.sv */
/* stream consumer standing for the host reading frame words.
   assumes the block's pclk domain; stall is set by the testbench. */
`timescale 1ns/1ps
module acm_consumer
    import acm_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // async reset, active low
    input wire logic stall, // hold off taking words
    input wire logic frame_valid, // word offered
    input wire acm_word_t frame_word, // offered word
    output logic frame_ready, // take request
    output logic got, // one-cycle pulse per word taken
    output acm_word_t got_word // word taken
);
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            frame_ready <= 1'b0;
            got <= 1'b0;
            got_word <= '0;
        end
        else
        begin
            frame_ready <= !stall;
            got <= frame_valid && frame_ready;
            got_word <= frame_word;
        end
    end
endmodule : acm_consumer

/* dv/acm_top_assertions.sv */
/* concurrent checks on the ports of acm_top.
   assumes one pclk domain and the zero-wait apb slave. */
`timescale 1ns/1ps
module acm_chk
    import acm_pkg::*;
(
    input wire logic pclk, // clock
    input wire logic presetn, // reset
    input wire logic psel, // apb
    input wire logic penable, // apb
    input wire logic pwrite, // apb
    input wire logic [ADDR_W-1:0] paddr, // apb
    input wire logic [31:0] pwdata, // apb
    input wire logic [31:0] prdata, // apb
    input wire logic drdy, // frame pulse
    input wire logic frame_valid, // stream
    input wire logic frame_ready, // stream
    input wire acm_word_t frame_word, // stream
    input wire logic [ACM_LANES-1:0] lane_sleep, // standby
    input wire logic [ACM_LANES-1:0] lane_sinc5, // filter
    input wire logic [ACM_LANES-1:0][2:0] lane_dec_code, // decimation
    input wire logic common_mode_voltage_output, // cm enable
    input wire logic xtal_drive_en // crystal enable
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic [3:0] last_wd;
    always_ff @(posedge pclk)
    begin
        last_wd <= pwdata[3:0];
    end
    sleep_write_a: assert property (psel && penable && pwrite && paddr == 12'h000
        |=> lane_sleep == last_wd) else $error("standby write not applied");
    cm_gate_a: assert property (common_mode_voltage_output == !lane_sleep[0])
        else $error("common-mode enable wrong");
    xtal_gate_a: assert property (xtal_drive_en == !lane_sleep[2])
        else $error("crystal enable wrong");
    reset_vals_a: assert property ($rose(presetn) |-> lane_sinc5 == 4'hF &&
        lane_dec_code[3] == 3'h5) else $error("profile reset value wrong");
    rep_zero_a: assert property (frame_valid && frame_word.hdr.rep_data
        |-> frame_word.data == 24'h00_0000) else $error("repeat word carries data");
    drdy_valid_a: assert property (drdy |=> frame_valid)
        else $error("no word after data ready");
    drdy_single_a: assert property (drdy |=> !drdy[*3])
        else $error("data ready longer than a pulse");
    unused_zero_a: assert property (psel && penable && !pwrite && paddr == 12'h000
        |-> prdata[31:4] == 28'h000_0000) else $error("unused standby bits nonzero");
    word_hold_a: assert property (frame_valid && !frame_ready
        |=> frame_valid && $stable(frame_word)) else $error("stalled word changed");
    cover property (drdy);
    cover property (frame_valid && frame_word.hdr.rep_data);
    cover property (frame_valid && !frame_ready);
endmodule : acm_chk
bind acm_top acm_chk u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .drdy, .frame_valid, .frame_ready, .frame_word, .lane_sleep, .lane_sinc5,
    .lane_dec_code, .common_mode_voltage_output, .xtal_drive_en);

/* dv/acm_top_tb_top.sv */
/* self-checking bench for acm_top: apb register access and frame stream.
   assumes the consumer model on the stream side. */
`timescale 1ns/1ps
module acm_top_tb_top;
    import acm_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, mod_tick = 0, stall = 1;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic pready, pslverr, drdy, frame_valid, frame_ready, got, last_err;
    logic [3:0][23:0] lane_result = '0;
    acm_word_t frame_word, got_word;
    logic [3:0] lane_sleep, lane_sinc5;
    logic [3:0][2:0] lane_dec_code;
    logic cm_en, xtal_en;
    int bad_count = 0, n_compared = 0, n_drdy = 0;
    logic [31:0] words[$];
    logic [31:0] exp_rst[4] = '{32'h0000_0000, 32'h0000_000D, 32'h0000_000D, 32'h0000_0000};
    logic [31:0] exp_ff[4] = '{32'h0000_000F, 32'h0000_000F, 32'h0000_000F, 32'h0000_0033};
    acm_top uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .mod_tick(mod_tick), .lane_result(lane_result), .drdy(drdy),
        .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_word(frame_word),
        .lane_sleep(lane_sleep), .lane_sinc5(lane_sinc5), .lane_dec_code(lane_dec_code),
        .common_mode_voltage_output(cm_en), .xtal_drive_en(xtal_en));
    acm_consumer u_host (.pclk(pclk), .presetn(presetn), .stall(stall),
        .frame_valid(frame_valid), .frame_word(frame_word), .frame_ready(frame_ready),
        .got(got), .got_word(got_word));
    initial
    begin
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        if (got === 1'b1) words.push_back(got_word);
        if (drdy === 1'b1) n_drdy++;
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic wrap_up();
        if (bad_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    // lane word from the rules: lanes 1,3 on profile B (x64, wideband), lane 2 asleep
    function automatic logic [31:0] ew(input int l, input logic hit);
        if (l == 2) return 32'h0000_0000;
        return {1'b0, !hit, l % 2 == 0, 3'b000, 2'(l), hit ? 24'hAB_0000 | 24'(l) : 24'h0};
    endfunction : ew
    initial
    begin
        repeat (20000) @(posedge pclk);
        bad_count++;
        wrap_up();
    end
    initial
    begin
        for (int i = 0; i < 4; i++) lane_result[i] <= 24'hAB_0000 | 24'(i);
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            apb(0, 12'(4 * i), 0);
            chk(rd, exp_rst[i]);
            apb(1, 12'(4 * i), 32'hFFFF_FFFF);
            apb(0, 12'(4 * i), 0);
            chk(rd, exp_ff[i]);
        end
        apb(0, 12'h014, 0);
        chk({rd[30:0], last_err}, 32'h0000_0001);
        // a write lands at the access edge, so look one edge later
        apb(1, 12'h000, 32'h0000_0005);
        @(posedge pclk);
        chk({lane_sleep, cm_en, xtal_en}, 32'h0000_0014);
        apb(1, 12'h000, 32'h0000_0000);
        @(posedge pclk);
        chk({cm_en, xtal_en}, 32'h0000_0003);
        apb(1, 12'h00C, 32'h0000_0011);
        for (int c = 0; c < 8; c++)
        begin
            apb(1, 12'h004, 32'(c));
            apb(1, 12'h008, 32'(7 - c) | 32'h8);
            @(posedge pclk);
            chk({lane_dec_code, lane_sinc5}, {3'(c), 3'(7 - c), 3'(c), 3'(7 - c), 4'b0101});
        end
        apb(1, 12'h004, 32'h0000_0008);
        apb(1, 12'h008, 32'h0000_0001);
        apb(1, 12'h00C, 32'h0000_0022);
        // lane 0 stays awake; no crystal here, so lane 2 may sleep
        apb(1, 12'h000, 32'h0000_0004);
        for (int t = 0; t < 64; t++)
        begin
            @(posedge pclk);
            mod_tick <= 1'b1;
        end
        @(posedge pclk);
        mod_tick <= 1'b0;
        repeat (10) @(posedge pclk);
        chk(frame_valid, 1'b1);
        chk(n_drdy, 2);
        stall <= 1'b0;
        repeat (20) @(posedge pclk);
        chk(frame_valid, 1'b0);
        chk(words.size(), 8);
        for (int f = 0; f < 2; f++)
            for (int l = 0; l < 4; l++)
                if (words.size() == 8) chk(words[4 * f + l], ew(l, l % 2 == 0 || f == 1));
        // stalled host: frames at 96 and 128 fill the FIFO, 160 sticks, 192 overruns
        stall <= 1'b1;
        mod_tick <= 1'b1;
        repeat (128) @(posedge pclk);
        mod_tick <= 1'b0;
        apb(0, 12'h010, 0);
        chk(rd, 32'h0000_0003);
        chk(n_drdy, 5);
        apb(1, 12'h010, 32'h0000_0002);
        apb(0, 12'h010, 0);
        chk(rd, 32'h0000_0001);
        wrap_up();
    end
endmodule : acm_top_tb_top
